// ==== core/sws_consts.svh ====
// Offsets, reset values, field positions and timing of the switch
// configuration bank. Assumes inclusion by bare name, once per unit.
`ifndef SWS_CONSTS_SVH
`define SWS_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define SWS_OFF_HS 8'h00
`define SWS_OFF_AUX 8'h01
`define SWS_OFF_RX 8'h10
`define SWS_OFF_PLO 8'h11
`define SWS_OFF_PHI 8'h12
`define SWS_OFF_EQLO 8'h13
`define SWS_OFF_EQHI 8'h14
`define SWS_OFF_TX 8'h20

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SWS_RST_HS 8'h40
`define SWS_RST_AUX 8'h40
`define SWS_RST_RX 8'h01
`define SWS_RST_PLO 8'h00
`define SWS_RST_PHI 8'h00
`define SWS_RST_EQLO 8'h00
`define SWS_RST_EQHI 8'h00
`define SWS_RST_TX 8'h03

// ----------------------------------------
// Field positions, bus address and illegal source code
// ----------------------------------------
`define SWS_EN_BIT 6
`define SWS_TERM_BIT 0
`define SWS_ADDR_HI 6'b100100
`define SWS_SRC_BAD 2'b11

// ----------------------------------------
// Timing
// ----------------------------------------
`define SWS_PULSE_MS 100
`define SWS_CLK_KHZ 200000
`define SWS_PULSE_CYCLES (`SWS_PULSE_MS * `SWS_CLK_KHZ)

`endif

// ==== core/sws_pkg.sv ====
// Types shared by the switch configuration bank.
// Assumes nothing beyond a SystemVerilog compiler.
package sws_pkg;

  // Configuration as seen by the switch fabric
  typedef struct packed {
    logic fastPathEnable;
    logic [1:0] fastSourceSelect;
    logic sideSwitchEnable;
    logic [1:0] sideSourceSelect;
    logic inputTermOn;
    logic [11:0] eqLevelSelect;
    logic [1:0] outEmphasisLevel;
    logic outTermOn;
    logic outCurrentLevel;
  } sws_cfg_t;

  // Strapped parallel control pins
  typedef struct packed {
    logic enable;
    logic [1:0] source;
    logic eq;
    logic [1:0] emphasis;
    logic current;
  } sws_par_t;

  typedef enum logic [2:0] {
    ST_IDLE, ST_RECV, ST_ACK, ST_SEND, ST_MACK
  } sws_state_t;

  typedef enum logic [1:0] {
    PH_DEV, PH_REG, PH_DATA
  } sws_phase_t;

endpackage : sws_pkg

// ==== core/sws_config_regs.sv ====
// Configuration register bank of a three-to-one link switch, reached
// as a slave on a two-wire serial bus. Assumes SCL, SDA, the address
// strap and the parallel pins are asynchronous; SDA is open drain.
//
// Notes on behaviour
// - All registers readable and writable over serial bus
// - Address LSB follows the address strap pin
// - Serial addressing disables parallel pins until reset
// - Auxiliary mode register, enable bit6, reset 0x40
// - Input termination bit0 at 0x10, reset on
// - Pulse enables A/B channels at 0x11
// - Pulse enables C channels at 0x12 low
// - Pulse bit drops termination on fast source change
// - Transmitter settings at 0x20, reset 0x03
// - Upper address bits 100100, sent MSB first
// - Source codes 00/01/10 select A/B/C
// - Termination dropped for 100 ms
// - Fast enable clear puts channels in standby
`include "sws_consts.svh"

module sws_config_regs #(
  parameter int PULSE_CYCLES = `SWS_PULSE_CYCLES
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOeN,
  input wire logic slaveAddrLsbStrap,
  input wire sws_pkg::sws_par_t parPins,
  output sws_pkg::sws_cfg_t cfgOut,
  output logic [11:0] inputTermConnect,
  output logic serialActive
);
  import sws_pkg::*;

  localparam int PW = $bits(sws_par_t);
  localparam int SW = PW + 3;
  localparam int CW = $clog2(PULSE_CYCLES + 1);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  logic [SW-1:0] syncA_reg;
  logic [SW-1:0] syncB_reg;
  logic sclPrev_reg;
  logic sdaPrev_reg;
  wire [SW-1:0] rawIn = {sclIn, sdaIn, slaveAddrLsbStrap, parPins};

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      // Bus lines rest high, so no false edge follows reset
      syncA_reg <= {2'b11, {(SW-2){1'b0}}};
      syncB_reg <= {2'b11, {(SW-2){1'b0}}};
      sclPrev_reg <= 1'b1;
      sdaPrev_reg <= 1'b1;
    end else begin
      syncA_reg <= rawIn;
      syncB_reg <= syncA_reg;
      sclPrev_reg <= syncB_reg[SW-1];
      sdaPrev_reg <= syncB_reg[SW-2];
    end
  end

  wire sclS = syncB_reg[SW-1];
  wire sdaS = syncB_reg[SW-2];
  wire strapS = syncB_reg[SW-3];
  sws_par_t parS;
  assign parS = sws_par_t'(syncB_reg[PW-1:0]);

  wire sclRise = sclS & ~sclPrev_reg;
  wire sclFall = ~sclS & sclPrev_reg;
  wire bothHigh = sclS & sclPrev_reg;
  wire startCond = bothHigh & sdaPrev_reg & ~sdaS;
  wire stopCond = bothHigh & ~sdaPrev_reg & sdaS;

  // ----------------------------------------
  // Register storage
  // ----------------------------------------
  logic [2:0] hsMode_reg;
  logic [2:0] auxMode_reg;
  logic rxTerm_reg;
  logic [7:0] pulseLo_reg;
  logic [3:0] pulseHi_reg;
  logic [7:0] eqLo_reg;
  logic [3:0] eqHi_reg;
  logic [3:0] txSet_reg;

  // Reserved bits always read as zero
  function automatic logic [7:0] readByte(input logic [7:0] ptr);
    logic [7:0] v;
    v = 8'h00;
    case (ptr)
      `SWS_OFF_HS: v = {1'b0, hsMode_reg[2], 4'h0,
                        hsMode_reg[1:0]};
      `SWS_OFF_AUX: v = {1'b0, auxMode_reg[2], 4'h0,
                         auxMode_reg[1:0]};
      `SWS_OFF_RX: v = {7'h00, rxTerm_reg};
      `SWS_OFF_PLO: v = pulseLo_reg;
      `SWS_OFF_PHI: v = {4'h0, pulseHi_reg};
      `SWS_OFF_EQLO: v = eqLo_reg;
      `SWS_OFF_EQHI: v = {4'h0, eqHi_reg};
      `SWS_OFF_TX: v = {4'h0, txSet_reg};
      default: v = 8'h00;
    endcase
    return v;
  endfunction : readByte

  // ----------------------------------------
  // Serial slave
  // ----------------------------------------
  sws_state_t state_reg;
  sws_phase_t phase_reg;
  logic [3:0] bitCnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] regPtr_reg;
  logic readMode_reg;
  logic sdaDrive_reg;
  logic serialSeen_reg;

  wire byteDone = (state_reg == ST_RECV) & sclFall & (bitCnt_reg == 4'h8);
  wire devMatch = shift_reg[7:1] == {`SWS_ADDR_HI, strapS};
  wire devByte = byteDone & (phase_reg == PH_DEV);
  wire addrHit = devByte & devMatch;
  wire addrMiss = devByte & ~devMatch;
  wire wrStrobe = byteDone & (phase_reg == PH_DATA);
  // Process form so that register updates, not only pointer moves, refresh it
  logic [7:0] rdByte;
  always_comb rdByte = readByte(regPtr_reg);
  wire [7:0] ptrInc = regPtr_reg + 8'h01;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state_reg <= ST_IDLE;
      phase_reg <= PH_DEV;
      bitCnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      regPtr_reg <= 8'h00;
      readMode_reg <= 1'b0;
      sdaDrive_reg <= 1'b0;
    end else if (startCond) begin
      state_reg <= ST_RECV;
      phase_reg <= PH_DEV;
      bitCnt_reg <= 4'h0;
      sdaDrive_reg <= 1'b0;
    end else if (stopCond) begin
      state_reg <= ST_IDLE;
      sdaDrive_reg <= 1'b0;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
        end
        ST_RECV: begin
          if (sclRise && bitCnt_reg != 4'h8) begin
            shift_reg <= {shift_reg[6:0], sdaS};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end else if (addrMiss) begin
            state_reg <= ST_IDLE;
          end else if (byteDone) begin
            state_reg <= ST_ACK;
            sdaDrive_reg <= 1'b1;
            bitCnt_reg <= 4'h0;
            if (phase_reg == PH_DEV) begin
              readMode_reg <= shift_reg[0];
              phase_reg <= PH_REG;
            end else if (phase_reg == PH_REG) begin
              regPtr_reg <= shift_reg;
              phase_reg <= PH_DATA;
            end else begin
              regPtr_reg <= ptrInc;
            end
          end
        end
        ST_ACK, ST_MACK: begin
          if (state_reg == ST_MACK && sclRise && sdaS) begin
            state_reg <= ST_IDLE;
          end else if (sclFall && readMode_reg) begin
            state_reg <= ST_SEND;
            shift_reg <= rdByte;
            sdaDrive_reg <= ~rdByte[7];
            regPtr_reg <= ptrInc;
            bitCnt_reg <= 4'h1;
          end else if (sclFall) begin
            state_reg <= ST_RECV;
            sdaDrive_reg <= 1'b0;
          end
        end
        ST_SEND: begin
          if (sclFall && bitCnt_reg == 4'h8) begin
            state_reg <= ST_MACK;
            sdaDrive_reg <= 1'b0;
          end else if (sclFall) begin
            sdaDrive_reg <= ~shift_reg[6];
            shift_reg <= {shift_reg[6:0], 1'b0};
            bitCnt_reg <= bitCnt_reg + 4'h1;
          end
        end
      endcase
    end
  end

  // Open drain: only ever pulls low
  assign sdaOut = 1'b0;
  assign sdaOeN = ~sdaDrive_reg;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  wire [7:0] wd = shift_reg;
  // Code 11 would leave no source routed, so the source field of such a write is dropped; the enable bit is still stored
  wire srcOk = wd[1:0] != `SWS_SRC_BAD;
  localparam logic [7:0] RHS = `SWS_RST_HS;
  localparam logic [7:0] RAUX = `SWS_RST_AUX;
  localparam logic [7:0] RRX = `SWS_RST_RX;
  localparam logic [7:0] RPLO = `SWS_RST_PLO;
  localparam logic [7:0] RPHI = `SWS_RST_PHI;
  localparam logic [7:0] REQLO = `SWS_RST_EQLO;
  localparam logic [7:0] REQHI = `SWS_RST_EQHI;
  localparam logic [7:0] RTX = `SWS_RST_TX;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      hsMode_reg <= {RHS[`SWS_EN_BIT], RHS[1:0]};
      auxMode_reg <= {RAUX[`SWS_EN_BIT], RAUX[1:0]};
      rxTerm_reg <= RRX[`SWS_TERM_BIT];
      pulseLo_reg <= RPLO;
      pulseHi_reg <= RPHI[3:0];
      eqLo_reg <= REQLO;
      eqHi_reg <= REQHI[3:0];
      txSet_reg <= RTX[3:0];
    end else if (wrStrobe) begin
      case (regPtr_reg)
        `SWS_OFF_HS: begin
          hsMode_reg[2] <= wd[`SWS_EN_BIT];
          if (srcOk) hsMode_reg[1:0] <= wd[1:0];
        end
        `SWS_OFF_AUX: begin
          auxMode_reg[2] <= wd[`SWS_EN_BIT];
          if (srcOk) auxMode_reg[1:0] <= wd[1:0];
        end
        `SWS_OFF_RX: rxTerm_reg <= wd[`SWS_TERM_BIT];
        `SWS_OFF_PLO: pulseLo_reg <= wd;
        `SWS_OFF_PHI: pulseHi_reg <= wd[3:0];
        `SWS_OFF_EQLO: eqLo_reg <= wd;
        `SWS_OFF_EQHI: eqHi_reg <= wd[3:0];
        `SWS_OFF_TX: txSet_reg <= wd[3:0];
        default: begin
        end
      endcase
    end
  end

  // ----------------------------------------
  // Control source and termination pulse
  // ----------------------------------------
  always_ff @(posedge clk) begin
    if (!reset_n) serialSeen_reg <= 1'b0;
    else if (addrHit) serialSeen_reg <= 1'b1;
  end

  sws_cfg_t serCfg;
  sws_cfg_t parCfg;
  sws_cfg_t cfgNext;
  assign serCfg = '{hsMode_reg[2], hsMode_reg[1:0], auxMode_reg[2],
                    auxMode_reg[1:0], rxTerm_reg, {eqHi_reg, eqLo_reg},
                    txSet_reg[3:2], txSet_reg[1], txSet_reg[0]};
  assign parCfg = '{parS.enable, parS.source, auxMode_reg[2],
                    auxMode_reg[1:0], rxTerm_reg, {12{parS.eq}},
                    parS.emphasis, txSet_reg[1], parS.current};
  assign cfgNext = serialSeen_reg ? serCfg : parCfg;

  logic [CW-1:0] pulseCnt_reg;
  wire srcChange = cfgNext.fastSourceSelect != cfgOut.fastSourceSelect;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cfgOut <= parCfg;
      pulseCnt_reg <= '0;
    end else begin
      // Fast enable low leaves the fabric in standby
      cfgOut <= cfgNext;
      if (srcChange) pulseCnt_reg <= CW'(PULSE_CYCLES);
      else if (pulseCnt_reg != '0) pulseCnt_reg <= pulseCnt_reg - 1'b1;
    end
  end

  wire pulsing = pulseCnt_reg != '0;
  wire [11:0] pulseVec = {pulseHi_reg, pulseLo_reg};
  assign inputTermConnect = {12{cfgOut.inputTermOn}}
                          & ~(pulseVec & {12{pulsing}});
  assign serialActive = serialSeen_reg;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  sequence seqAddrAck;
    addrHit ##1 (!sdaOeN && state_reg == ST_ACK);
  endsequence

  chk_addr_ack: assert property (
    devByte && devMatch |-> seqAddrAck)
    else $error("Matching address not acknowledged");

  chk_addr_miss: assert property (
    addrMiss |=> sdaOeN && state_reg == ST_IDLE)
    else $error("Foreign address acknowledged");

  chk_serial_lock: assert property (
    addrHit |=> serialSeen_reg [*8])
    else $error("Parallel control not locked out");

  chk_par_follow: assert property (
    !serialSeen_reg && !addrHit |=>
      cfgOut.fastPathEnable == $past(parS.enable))
    else $error("Parallel enable not followed");

  chk_hs_zero: assert property (
    regPtr_reg == `SWS_OFF_HS |-> rdByte[5:2] == 4'h0
      && rdByte[6] == hsMode_reg[2])
    else $error("High-speed mode readback wrong");

  chk_aux_zero: assert property (
    regPtr_reg == `SWS_OFF_AUX |-> rdByte[7:2] == {1'b0,
      auxMode_reg[2], 4'h0})
    else $error("Auxiliary mode readback wrong");

  chk_phi_zero: assert property (
    regPtr_reg == `SWS_OFF_PHI |-> rdByte[7:4] == 4'h0)
    else $error("Pulse high reserved bits set");

  chk_tx_write: assert property (
    wrStrobe && regPtr_reg == `SWS_OFF_TX |=>
      txSet_reg == $past(wd[3:0]) ##1 cfgOut.outCurrentLevel ==
      $past(txSet_reg[0]) || !serialSeen_reg)
    else $error("Transmitter write not stored");

  chk_src_legal: assert property (
    serialSeen_reg |-> hsMode_reg[1:0] != `SWS_SRC_BAD)
    else $error("Illegal source code stored");

  chk_pulse_start: assert property (
    srcChange |=> pulseCnt_reg == CW'(PULSE_CYCLES))
    else $error("Termination pulse not started");

  chk_pulse_drop: assert property (
    pulsing |-> (inputTermConnect & pulseVec) == 12'h000)
    else $error("Pulsed channel left terminated");

endmodule : sws_config_regs

// ==== verif/sws_master.sv ====
// Two-wire bus master model that drives the switch configuration bank.
// Assumes the bench resolves SDA as a pulled-up wired-AND of all drivers.
module sws_master (
  input wire logic clk,
  input wire logic sdaLine,
  output logic scl,
  output logic sdaDrvN
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    scl = 1'b1;
    sdaDrvN = 1'b1;
  end

  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask : hold

  // Serves as repeated start too: SDA is released while SCL is low
  task automatic start;
    sdaDrvN = 1'b1;
    hold(6);
    scl = 1'b1;
    hold(6);
    sdaDrvN = 1'b0;
    hold(6);
    scl = 1'b0;
    hold(2);
  endtask : start

  task automatic stop;
    sdaDrvN = 1'b0;
    hold(6);
    scl = 1'b1;
    hold(6);
    sdaDrvN = 1'b1;
    hold(6);
  endtask : stop

  // Gap after the SCL fall keeps SDA moves clear of a false start or stop
  task automatic bitIo(input logic b, output logic r);
    sdaDrvN = b;
    hold(6);
    scl = 1'b1;
    hold(4);
    r = sdaLine;
    hold(4);
    scl = 1'b0;
    hold(2);
  endtask : bitIo

  task automatic sendByte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bitIo(d[i], r);
    bitIo(1'b1, r);
    ack = ~r;
  endtask : sendByte

  task automatic recvByte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 0; i < 8; i++) begin
      bitIo(1'b1, r);
      d = {d[6:0], r};
    end
    bitIo(~more, r);
  endtask : recvByte

  task automatic writeReg(input logic [6:0] dev, input logic [7:0] off,
                          input logic [7:0] dat, output logic ok);
    logic a0, a1, a2;
    start();
    sendByte({dev, 1'b0}, a0);
    ok = a0;
    if (a0) begin
      sendByte(off, a1);
      sendByte(dat, a2);
      ok = a1 & a2;
    end
    stop();
  endtask : writeReg

  task automatic readReg(input logic [6:0] dev, input logic [7:0] off,
                         output logic [7:0] d, output logic ok);
    logic a0, a1, a2;
    start();
    sendByte({dev, 1'b0}, a0);
    sendByte(off, a1);
    start();
    sendByte({dev, 1'b1}, a2);
    recvByte(1'b0, d);
    stop();
    ok = a0 & a1 & a2;
  endtask : readReg
endmodule : sws_master

// ==== verif/testbench.sv ====
// Self-checking bench for the switch configuration bank.
// Assumes the bus master model in sws_master and the shared constants.
`include "sws_consts.svh"

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import sws_pkg::*;

  localparam int PC = 200;
  localparam int LIMIT = 90000;
  localparam logic [7:0] OFFS [8] = '{8'h00, 8'h01, 8'h10, 8'h11, 8'h12,
                                      8'h13, 8'h14, 8'h20};
  localparam logic [7:0] MASKS [8] = '{8'h43, 8'h43, 8'h01, 8'hff, 8'h0f,
                                       8'hff, 8'h0f, 8'h0f};
  localparam logic [7:0] RSTS [8] = '{8'h40, 8'h40, 8'h01, 8'h00, 8'h00,
                                      8'h00, 8'h00, 8'h03};

  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic strap = 1'b0;
  sws_par_t par = '0;
  logic [31:0] rnd = 32'h5071;
  wire logic sda;
  logic scl, mstDrvN, devOut, devOeN, serAct, ok;
  sws_cfg_t cfg;
  logic [11:0] termConn;
  logic [7:0] mdl [8];
  logic [7:0] d;
  logic [1:0] src;
  int num_errors = 0;
  int compares = 0;
  int cycles = 0;

  assign sda = mstDrvN & (devOeN | devOut);

  always #2.5 clk = ~clk;

  sws_config_regs #(.PULSE_CYCLES(PC)) uut (.clk(clk), .reset_n(reset_n),
    .sclIn(scl), .sdaIn(sda), .sdaOut(devOut), .sdaOeN(devOeN),
    .slaveAddrLsbStrap(strap), .parPins(par), .cfgOut(cfg),
    .inputTermConnect(termConn), .serialActive(serAct));

  sws_master mst (.clk(clk), .sdaLine(sda), .scl(scl), .sdaDrvN(mstDrvN));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] nextRnd(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRnd

  // Before the first address match the straps own part of the image
  function automatic sws_cfg_t expCfg(input logic ser);
    sws_cfg_t c;
    c = {mdl[0][6], mdl[0][1:0], mdl[1][6], mdl[1][1:0], mdl[2][0],
         mdl[6][3:0], mdl[5], mdl[7][3:0]};
    if (!ser) begin
      c.fastPathEnable = par.enable;
      c.fastSourceSelect = par.source;
      c.eqLevelSelect = {12{par.eq}};
      c.outEmphasisLevel = par.emphasis;
      c.outCurrentLevel = par.current;
    end
    return c;
  endfunction : expCfg

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic give_verdict;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  task automatic endTest(input string n);
    $display("test %s done, errors so far %0d", n, num_errors);
  endtask : endTest

  // Code 11 in a select field leaves the old selection standing
  task automatic wr(input int i, input logic [7:0] v);
    logic [7:0] nv;
    mst.writeReg({`SWS_ADDR_HI, strap}, OFFS[i], v, ok);
    check(ok, 1);
    nv = v & MASKS[i];
    if (i < 2 && v[1:0] == `SWS_SRC_BAD)
      nv[1:0] = mdl[i][1:0];
    mdl[i] = nv;
  endtask : wr

  task automatic rdChk(input int i);
    mst.readReg({`SWS_ADDR_HI, strap}, OFFS[i], d, ok);
    check(ok, 1);
    check(d, mdl[i]);
  endtask : rdChk

  task automatic doReset;
    reset_n = 1'b0;
    for (int i = 0; i < 8; i++) mdl[i] = RSTS[i];
    repeat (6) @(negedge clk);
    reset_n = 1'b1;
    repeat (5) @(negedge clk);
  endtask : doReset

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      num_errors++;
      give_verdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rnd = nextRnd(rnd);
    strap = rnd[3];
    par = rnd[10:4];
    par.source = {rnd[6] & ~rnd[5], rnd[5]};
    doReset();
    check(cfg, expCfg(1'b0));
    check(serAct, 0);
    endTest("parallel");
    mst.writeReg({`SWS_ADDR_HI, ~strap}, 8'h20, 8'h0c, ok);
    check(ok, 0);
    check(serAct, 0);
    check(cfg, expCfg(1'b0));
    endTest("address");
    for (int i = 0; i < 8; i++)
      rdChk(i);
    mst.readReg({`SWS_ADDR_HI, strap}, 8'h05, d, ok);
    check(d, 0);
    check(serAct, 1);
    check(cfg, expCfg(1'b1));
    endTest("defaults");
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 8; i++) begin
        rnd = nextRnd(rnd);
        wr(i, rnd[7:0]);
      end
      wr(k, {rnd[15:10], 2'b11});
      for (int i = 0; i < 8; i++) rdChk(i);
      check(cfg, expCfg(1'b1));
    end
    endTest("random");
    wr(2, 8'h01);
    wr(3, 8'ha5);
    wr(4, 8'h06);
    repeat (PC + 20) @(negedge clk);
    check(termConn, 12'hfff);
    src = (mdl[0][1:0] == 2'b10) ? 2'b00 : mdl[0][1:0] + 2'b01;
    wr(0, {6'h10, src});
    check(termConn, 12'hfff ^ {mdl[4][3:0], mdl[3]});
    check(cfg, expCfg(1'b1));
    repeat (PC) @(negedge clk);
    check(termConn, 12'hfff);
    wr(2, 8'h00);
    check(termConn, 0);
    wr(0, 8'h02);
    check(cfg.fastPathEnable, 0);
    check(cfg, expCfg(1'b1));
    endTest("pulse");
    doReset();
    check(serAct, 0);
    check(cfg, expCfg(1'b0));
    endTest("second reset");
    give_verdict();
  end
endmodule : testbench
